// File: i2c_slave_recover.sv
// Purpose: i2c slave serial state machine with start/stop recovery
// Assumes: scl and sda synchronous to clock_in
// Notes: a written byte pair (pointer, data) is committed only at stop
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_recover
  import i2c_recovery_pkg::*;
#(
  parameter logic [6:0] ADDR = DEFAULT_ADDR
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // link
  i2c_link_if.slave bus,
  // user side: read data and committed write
  input wire logic [7:0] read_data_in,
  output logic write_strobe_out,
  output logic [7:0] write_reg_out,
  output logic [7:0] write_data_out,
  output logic [1:0] channel_reference_select_out,
  output logic supply_ref_out,
  output logic busy_out
);
  // one-hot protocol states; ignore sits out a mismatched address or a
  // not-acknowledged read until the next start or stop
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_RX = 5'b00100,
    ST_TX = 5'b01000,
    ST_IGNORE = 5'b10000
  } state_t;

  // bit counter: 0 to 7 are data bits, 8 is the acknowledge slot; the
  // scl fall that completes a start is not a bit, so a start parks the
  // counter one below zero and that fall wraps it round to 0
  localparam logic [3:0] BIT_PRE = 4'hf;

  state_t state_q;
  // line levels one clock ago, for edge and condition detection
  logic scl_q;
  logic sda_q;
  // serial protocol state: recovery clears all but shift_q, and also clears pending_q
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic sda_oe_q;
  logic [1:0] bytes_q;
  // write capture and configuration: recovery leaves these alone, except pending_q, which a start clears
  logic [7:0] reg_q;
  logic [7:0] data_q;
  logic pending_q;
  logic [1:0] ref_q;
  // decode of a complete address byte: seven address bits, then the
  // read flag in bit 0
  logic addr_match;
  logic read_req;
  wire logic scl_rise = bus.scl & ~scl_q;
  wire logic scl_fall = ~bus.scl & scl_q;
  // both conditions need scl high on two samples in a row, so a data
  // change that lands with an scl edge is never taken for one
  wire logic start_c = bus.scl & scl_q & sda_q & ~bus.sda;
  wire logic stop_c = bus.scl & scl_q & ~sda_q & bus.sda;

  assign addr_match = (shift_q[7:1] == ADDR);
  assign read_req = shift_q[0];

  // reset to the released levels so no false edge follows reset
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= bus.scl;
      sda_q <= bus.sda;
    end
  end

  // protocol machine; recovery clears this state except shift_q, and pending_q below
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      sda_oe_q <= 1'b0;
      bytes_q <= 2'h0;
    end else if (start_c) begin
      state_q <= ST_ADDR;
      bit_q <= BIT_PRE;
      sda_oe_q <= 1'b0;
      bytes_q <= 2'h0;
    end else if (stop_c) begin
      state_q <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      case (state_q)
        // data is taken on the scl rise, acknowledge driven from the fall
        ST_ADDR, ST_RX: begin
          if (scl_rise && bit_q < 4'd8) begin
            shift_q <= {shift_q[6:0], bus.sda};
          end
          if (scl_fall) begin
            bit_q <= (bit_q == 4'd8) ? 4'h0 : bit_q + 4'd1;
            if (bit_q == 4'd7) begin
              if (state_q == ST_ADDR) begin
                // acknowledge only our own address; otherwise stay off
                // the data line until the next start
                sda_oe_q <= addr_match;
              end else begin
                sda_oe_q <= 1'b1;
              end
            end else if (bit_q == 4'd8) begin
              sda_oe_q <= 1'b0;
              if (!sda_oe_q) begin
                state_q <= ST_IGNORE;
              end else if (state_q == ST_ADDR && read_req) begin
                // first read bit is driven from this same scl fall
                state_q <= ST_TX;
                shift_q <= read_data_in;
                sda_oe_q <= ~read_data_in[7];
                bit_q <= 4'h0;
              end else begin
                state_q <= ST_RX;
                if (state_q == ST_RX && bytes_q != 2'h3) begin
                  bytes_q <= bytes_q + 2'h1;
                end
              end
            end
          end
        end
        ST_TX: begin
          // a released acknowledge slot is a not-acknowledge: let go of
          // the line, even in the middle of a recovery's nine ones
          if (scl_rise && bit_q == 4'd8 && bus.sda) begin
            state_q <= ST_IGNORE;
          end
          if (scl_fall) begin
            if (bit_q == 4'd8) begin
              bit_q <= 4'h0;
              shift_q <= read_data_in;
              sda_oe_q <= ~read_data_in[7];
            end else begin
              bit_q <= bit_q + 4'd1;
              shift_q <= {shift_q[6:0], 1'b0};
              sda_oe_q <= (bit_q == 4'd7) ? 1'b0 : ~shift_q[6];
            end
          end
        end
        ST_IGNORE: sda_oe_q <= 1'b0;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // capture of write bytes, commit deferred to stop
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      reg_q <= 8'h00;
      data_q <= 8'h00;
      pending_q <= 1'b0;
    end else if (start_c) begin
      // a start before the stop throws the captured pair away
      pending_q <= 1'b0;
    end else if (state_q == ST_RX && scl_fall && bit_q == 4'd7) begin
      if (bytes_q == 2'h0) begin
        reg_q <= shift_q;
      end else if (bytes_q == 2'h1) begin
        data_q <= shift_q;
        pending_q <= 1'b1;
      end
    end else if (stop_c) begin
      pending_q <= 1'b0;
    end
  end

  // configuration is never touched by recovery
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      write_strobe_out <= 1'b0;
      write_reg_out <= 8'h00;
      write_data_out <= 8'h00;
      ref_q <= REF_SUPPLY;
      supply_ref_out <= 1'b1;
    end else begin
      write_strobe_out <= stop_c & pending_q;
      if (stop_c && pending_q) begin
        write_reg_out <= reg_q;
        write_data_out <= data_q;
        ref_q <= data_q[1:0];
      end
      // the flag trails the select by one clock
      supply_ref_out <= (ref_q == REF_SUPPLY);
    end
  end

  // ignore counts as busy: the slave is mid-frame until a stop
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= (state_q != ST_IDLE);
    end
  end

  // both come straight from flip-flops
  assign bus.sda_oe_s = sda_oe_q;
  assign channel_reference_select_out = ref_q;
endmodule
`default_nettype wire

// File: i2c_recovery_pkg.sv
// Purpose: shared constants for the i2c slave and its recovering master
// Assumes: one 100 MHz clock on both ends, open-drain lines as three signals
// Notes: SCL and SDA are sampled on clock_in, no metastability filter
package i2c_recovery_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SCL_HALF_NS = 5000;
  localparam int unsigned SCL_HALF_CYC = (SCL_HALF_NS + CLK_PERIOD_NS - 1)
                                         / CLK_PERIOD_NS;
  localparam int unsigned RECOVERY_ONES = 9;
  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [6:0] DEFAULT_ADDR = 7'h60;
endpackage

// File: i2c_link_if.sv
// Purpose: open-drain two-wire link between master and slave ends
// Assumes: pull-ups hold a released line high
// Notes: wired-and of the output enables
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
  logic scl_oe_m;
  logic sda_oe_m;
  logic sda_oe_s;
  logic scl;
  logic sda;
  assign scl = ~scl_oe_m;
  assign sda = ~(sda_oe_m | sda_oe_s);
  modport master (output scl_oe_m, output sda_oe_m, input scl, input sda);
  modport slave (output sda_oe_s, input scl, input sda);
endinterface
`default_nettype wire

// File: i2c_master_recover.sv
// Purpose: master end issuing presence probe and recovery sequence
// Assumes: no clock stretching, single master
// Notes: bit-level sequencer, two steps per scl half period
`timescale 1ns/1ps
`default_nettype none
module i2c_master_recover
  import i2c_recovery_pkg::*;
#(
  parameter int unsigned HALF_CYC = SCL_HALF_CYC
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // link
  i2c_link_if.master bus,
  // user commands
  input wire logic probe_in,
  input wire logic recover_in,
  input wire logic [6:0] addr_in,
  // results
  output logic done_out,
  output logic present_out,
  output logic busy_out
);
  // the phase sequencer needs two clocks per step, and the tick
  // counter is sixteen bits wide
  if (HALF_CYC < 2 || HALF_CYC > 65536) begin : g_half_check
    $error("HALF_CYC out of range");
  end
  typedef enum logic [3:0] {
    MS_IDLE = 4'b0001,
    MS_START = 4'b0010,
    MS_BITS = 4'b0100,
    MS_STOP = 4'b1000
  } mstate_t;

  mstate_t st_q;
  logic [15:0] tick_q;
  logic [1:0] phase_q;
  logic [4:0] idx_q;
  logic [4:0] nbits_q;
  logic [17:0] seq_q;
  logic recov_q;
  logic starts_q;
  logic scl_oe_q, sda_oe_q;
  wire logic step = (tick_q == 16'(HALF_CYC - 1));

  always_ff @(posedge clock_in) begin
    if (!rstn_in || st_q == MS_IDLE || step) begin
      tick_q <= 16'h0000;
    end else begin
      tick_q <= tick_q + 16'h0001;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      st_q <= MS_IDLE;
      phase_q <= 2'h0;
      idx_q <= 5'h00;
      nbits_q <= 5'h00;
      seq_q <= 18'h0_0000;
      recov_q <= 1'b0;
      starts_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      done_out <= 1'b0;
      present_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (st_q)
        MS_IDLE: begin
          if (recover_in || probe_in) begin
            st_q <= MS_START;
            recov_q <= recover_in;
            starts_q <= 1'b0;
            phase_q <= 2'h0;
            // recovery: nine released ones; probe: address, read, ack slot
            seq_q <= recover_in ? {9'h1ff, 9'h000} :
                     {addr_in, 1'b1, 1'b1, 9'h000};
            nbits_q <= 5'd9;
          end
        end
        MS_START: if (step) begin
          phase_q <= phase_q + 2'h1;
          case (phase_q)
            2'h0: sda_oe_q <= 1'b0;
            2'h1: scl_oe_q <= 1'b0;
            2'h2: sda_oe_q <= 1'b1;
            default: begin
              scl_oe_q <= 1'b1;
              phase_q <= 2'h0;
              idx_q <= 5'h00;
              if (recov_q && starts_q) begin
                st_q <= MS_STOP;
              end else begin
                st_q <= MS_BITS;
              end
            end
          endcase
        end
        MS_BITS: if (step) begin
          phase_q <= phase_q + 2'h1;
          case (phase_q)
            2'h0: sda_oe_q <= ~seq_q[17];
            2'h1: scl_oe_q <= 1'b0;
            2'h2: begin
              if (!recov_q && idx_q == 5'd8) begin
                present_out <= ~bus.sda;
              end
            end
            default: begin
              scl_oe_q <= 1'b1;
              phase_q <= 2'h0;
              seq_q <= {seq_q[16:0], 1'b0};
              idx_q <= idx_q + 5'd1;
              if (idx_q == nbits_q - 5'd1) begin
                starts_q <= 1'b1;
                st_q <= recov_q ? MS_START : MS_STOP;
              end
            end
          endcase
        end
        MS_STOP: if (step) begin
          phase_q <= phase_q + 2'h1;
          case (phase_q)
            2'h0: sda_oe_q <= 1'b1;
            2'h1: scl_oe_q <= 1'b0;
            2'h2: sda_oe_q <= 1'b0;
            default: begin
              st_q <= MS_IDLE;
              done_out <= 1'b1;
            end
          endcase
        end
        default: st_q <= MS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= (st_q != MS_IDLE);
    end
  end

  assign bus.scl_oe_m = scl_oe_q;
  assign bus.sda_oe_m = sda_oe_q;
endmodule
`default_nettype wire

// File: i2c_link_sva.sv
// Purpose: checker on the link between the master and slave ends
// Assumes: one clock domain, lines sampled on clock_in
// Notes: also watches the slave's user outputs
`timescale 1ns/1ps
`default_nettype none
module i2c_link_sva
  import i2c_recovery_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // link
  input wire logic scl_oe_m,
  input wire logic sda_oe_m,
  input wire logic sda_oe_s,
  input wire logic scl,
  input wire logic sda,
  // slave outputs
  input wire logic busy_out,
  input wire logic write_strobe_out,
  input wire logic [1:0] channel_reference_select_out,
  input wire logic supply_ref_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  logic scl_q;
  logic [3:0] held_q;
  always_ff @(posedge clock_in) begin
    scl_q <= scl;
  end
  // scl rises seen under one unbroken slave drive
  always_ff @(posedge clock_in) begin
    if (!rstn_in || !sda_oe_s) begin
      held_q <= 4'h0;
    end else if (scl && !scl_q && held_q != 4'hf) begin
      held_q <= held_q + 4'h1;
    end
  end
  sequence start_s;
    $fell(sda) && scl;
  endsequence
  sequence stop_s;
    $rose(sda) && scl;
  endsequence
  AST_RESET_LINES: assert property ($rose(rstn_in) |->
    !sda_oe_s && !sda_oe_m && !scl_oe_m) else $error("line driven at reset");
  AST_START_QUIET: assert property (start_s |=> !sda_oe_s [*8])
    else $error("slave drives right after start");
  AST_STOP_QUIET: assert property (stop_s |=> !sda_oe_s [*8])
    else $error("slave drives right after stop");
  AST_DRIVE_SCL_LOW: assert property ($changed(sda_oe_s) |-> !scl)
    else $error("slave data changed with clock high");
  // an acknowledge plus eight zero read bits is the longest legal drive
  AST_DRIVE_BOUNDED: assert property (held_q <= 4'h9)
    else $error("slave held data through a nack");
  AST_SUPPLY_REF: assert property ($stable(channel_reference_select_out)
    |-> supply_ref_out == (channel_reference_select_out == REF_SUPPLY))
    else $error("supply reference flag wrong");
  AST_STROBE_IDLE: assert property (write_strobe_out |-> scl && sda)
    else $error("write committed without stop");
  AST_STOP_BUSY: assert property (stop_s |-> ##[1:3] !busy_out)
    else $error("slave busy after stop");
  AST_IDLE_QUIET: assert property (!busy_out && $past(busy_out) == 1'b0
    |-> !sda_oe_s) else $error("idle slave drives data");
  cover property (start_s);
  cover property (stop_s);
  cover property ($rose(sda_oe_s));
endmodule
`default_nettype wire

// File: tb.sv
// Purpose: self-checking bench joining master and slave ends
// Assumes: short scl half period for simulation
// Notes: random probes, each followed by a recovery sequence
`timescale 1ns/1ps
`default_nettype none
module tb;
  import i2c_recovery_pkg::*;
  logic clock_in;
  logic rstn_in;
  logic probe_in;
  logic recover_in;
  logic [6:0] addr_in;
  logic [7:0] read_data_in;
  logic write_strobe_out;
  logic [1:0] channel_reference_select_out;
  logic supply_ref_out;
  logic slave_busy;
  logic done_out;
  logic present_out;
  logic master_busy;
  logic [7:0] write_reg_seen;
  logic [7:0] write_data_seen;
  logic sda_prev;
  int failures = 0;
  int n_checks = 0;
  int seed = 76;
  int n_strobes = 0;
  int n_starts = 0;
  i2c_link_if link ();
  i2c_slave_recover i2c_slave_recover_inst (.clock_in(clock_in),
    .rstn_in(rstn_in), .bus(link.slave), .read_data_in(read_data_in),
    .write_strobe_out(write_strobe_out), .write_reg_out(write_reg_seen),
    .write_data_out(write_data_seen),
    .channel_reference_select_out(channel_reference_select_out),
    .supply_ref_out(supply_ref_out), .busy_out(slave_busy));
  i2c_master_recover #(.HALF_CYC(4)) i2c_master_recover_inst (
    .clock_in(clock_in), .rstn_in(rstn_in), .bus(link.master),
    .probe_in(probe_in), .recover_in(recover_in), .addr_in(addr_in),
    .done_out(done_out), .present_out(present_out), .busy_out(master_busy));
  i2c_link_sva i2c_link_sva_inst (.clock_in(clock_in), .rstn_in(rstn_in),
    .scl_oe_m(link.scl_oe_m), .sda_oe_m(link.sda_oe_m),
    .sda_oe_s(link.sda_oe_s), .scl(link.scl), .sda(link.sda),
    .busy_out(slave_busy), .write_strobe_out(write_strobe_out),
    .channel_reference_select_out(channel_reference_select_out),
    .supply_ref_out(supply_ref_out));
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // link watch at the falling edge, away from where either end switches
  always @(negedge clock_in) begin
    if (write_strobe_out === 1'b1) n_strobes++;
    if (link.scl === 1'b1 && sda_prev === 1'b1 && link.sda === 1'b0) begin
      n_starts++;
    end
    sda_prev = link.sda;
  end
  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic run(input logic p, input logic r);
    int k;
    @(negedge clock_in);
    probe_in = p;
    recover_in = r;
    @(negedge clock_in);
    probe_in = 1'b0;
    recover_in = 1'b0;
    k = 0;
    while (done_out !== 1'b1 && k < 2000) begin
      @(posedge clock_in);
      #1;
      k++;
    end
    if (k >= 2000) failures++;
    repeat (4) @(negedge clock_in);
  endtask
  // a zero first read bit keeps data low, so the probe's stop is lost
  function automatic logic stuck(input logic [6:0] a, input logic [7:0] d);
    return (a == DEFAULT_ADDR) && !d[7];
  endfunction
  // a stuck slave hides the first recovery start under its low data bit
  function automatic logic [7:0] starts_exp(input logic [6:0] a,
                                            input logic [7:0] d);
    return stuck(a, d) ? 8'h01 : 8'h02;
  endfunction
  task automatic final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    // sixteen runs at their 2000-cycle limit, plus reset and margin
    #400000;
    failures++;
    final_report;
  end
  initial begin
    logic [6:0] a;
    logic [7:0] d;
    int s;
    rstn_in = 1'b0;
    probe_in = 1'b0;
    recover_in = 1'b0;
    addr_in = DEFAULT_ADDR;
    read_data_in = 8'h00;
    repeat (6) @(negedge clock_in);
    rstn_in = 1'b1;
    chk("sda idle", 8'h01, {7'h0, link.sda});
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      a = 7'($random(seed));
      if (i < 2 || d[0]) a = DEFAULT_ADDR;
      if (i == 0) d = 8'hff;
      if (i == 1) d = 8'h00;
      if (i == 2) a = DEFAULT_ADDR ^ 7'h01;
      addr_in = a;
      read_data_in = d;
      s = n_starts;
      run(1'b1, 1'b0);
      chk("present", {7'h0, a == DEFAULT_ADDR}, {7'h0, present_out});
      chk("stuck busy", {7'h0, stuck(a, d)}, {7'h0, slave_busy});
      chk("probe starts", 8'h01, 8'(n_starts - s));
      // recovery; on pass 3 probe is raised with it and recover must win
      s = n_starts;
      run(i == 3, 1'b1);
      chk("busy", 8'h00, {7'h0, slave_busy});
      chk("master busy", 8'h00, {7'h0, master_busy});
      chk("recovery starts", starts_exp(a, d), 8'(n_starts - s));
      chk("sda", 8'h01, {7'h0, link.sda});
      chk("held", {7'h0, a == DEFAULT_ADDR}, {7'h0, present_out});
      $display("test %0d done", i);
    end
    chk("ref select", 8'h00, {6'h0, channel_reference_select_out});
    chk("supply ref", 8'h01, {7'h0, supply_ref_out});
    chk("strobes", 8'h00, 8'(n_strobes));
    chk("write reg", 8'h00, write_reg_seen);
    chk("write data", 8'h00, write_data_seen);
    final_report;
  end
endmodule
`default_nettype wire
